// ### logic/otm_pkg.sv
// shared constants and types of the on-chip trace unit
package otm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets on the register port
  localparam logic [3:0] OTM_OFS_CMP_A_HIGH   = 4'h0;
  localparam logic [3:0] OTM_OFS_CMP_A_LOW    = 4'h1;
  localparam logic [3:0] OTM_OFS_CMP_B_HIGH   = 4'h2;
  localparam logic [3:0] OTM_OFS_CMP_B_LOW    = 4'h3;
  localparam logic [3:0] OTM_OFS_FIFO_HIGH    = 4'h4;
  localparam logic [3:0] OTM_OFS_FIFO_LOW     = 4'h5;
  localparam logic [3:0] OTM_OFS_CONTROL      = 4'h6;
  localparam logic [3:0] OTM_OFS_TRIGGER      = 4'h7;
  localparam logic [3:0] OTM_OFS_STATUS       = 4'h8;
  localparam logic [3:0] OTM_OFS_FORCE_RESET  = 4'h9;

  ////////////////////////////////////////////////////////////////////////////
  // control, trigger and force-reset field positions
  localparam int OTM_CTL_ENABLE      = 7;
  localparam int OTM_CTL_ARM         = 6;
  localparam int OTM_CTL_TAG         = 5;
  localparam int OTM_CTL_BRK_EN      = 4;
  localparam int OTM_CTL_DIR_A       = 3;
  localparam int OTM_CTL_DIR_A_EN    = 2;
  localparam int OTM_CTL_DIR_B       = 1;
  localparam int OTM_CTL_DIR_B_EN    = 0;
  localparam int OTM_TRG_QUALIFY     = 7;
  localparam int OTM_TRG_BEGIN       = 6;
  localparam int OTM_RST_REQ_BIT     = 0;
  localparam logic [7:0] OTM_TRG_WR_MASK = 8'hCF;

  ////////////////////////////////////////////////////////////////////////////
  // trigger modes, fifo size, reset values
  localparam logic [3:0] OTM_MODE_A_ONLY     = 4'h0;
  localparam logic [3:0] OTM_MODE_A_OR_B     = 4'h1;
  localparam logic [3:0] OTM_MODE_A_THEN_B   = 4'h2;
  localparam logic [3:0] OTM_MODE_EVENT_B    = 4'h3;
  localparam logic [3:0] OTM_MODE_A_EVENT_B  = 4'h4;
  localparam logic [3:0] OTM_MODE_A_AND_BD   = 4'h5;
  localparam logic [3:0] OTM_MODE_A_NOT_BD   = 4'h6;
  localparam logic [3:0] OTM_MODE_INSIDE     = 4'h7;
  localparam logic [3:0] OTM_MODE_OUTSIDE    = 4'h8;
  localparam int         OTM_FIFO_DEPTH      = 8;
  localparam logic [3:0] OTM_FIFO_FULL_CNT   = 4'h8;
  localparam logic [7:0] OTM_READ_ZERO       = 8'h00;
  localparam logic [7:0] OTM_CMP_RESET       = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef enum logic [1:0] {OTM_RUN_IDLE, OTM_RUN_SEEK, OTM_RUN_FILL}
    otm_run_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        rw;
    logic        valid;
    logic        fetch;
    logic        cof;
    logic        exec;
    logic [15:0] exec_addr;
  } otm_mon_type;

  typedef struct packed {
    logic [3:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
    logic       host;
  } otm_reg_req_type;

  typedef struct packed {
    logic [15:0]                         cmp_a;
    logic [15:0]                         cmp_b;
    logic [7:0]                          ctrl;
    logic [7:0]                          trig;
    logic                                af;
    logic                                bf;
    logic [3:0]                          cnt;
    otm_run_type                         run;
    logic [OTM_FIFO_DEPTH-1:0][15:0]     fifo;
    logic [15:0]                         last_fetch;
    logic [7:0]                          rd_data;
    logic                                brk_req;
    logic                                brk_tag;
    logic                                rst_req;
  } otm_state_type;

  localparam otm_state_type OTM_STATE_RESET = '0;

endpackage : otm_pkg

// ### logic/otm_trace_unit.sv
// on-chip trace unit: comparators, trigger, capture fifo, break requests
//
// Overview of operation
// RL1: force-reset reads zero; user writes ignored
// RL2: host write of 1 forces system reset
// RL3: comparator bytes reset zero, writable only unarmed
// RL4: ten bytes: three words, four byte registers
// RL5: fifo high read-only; zero in event modes
// RL6: high read holds fifo; low read advances
// RL7: event modes store byte data in low half
// RL8: armed low reads do not advance fifo
// RL9: unarmed low read stores last opcode address
// RL10: profiling works as eight-deep delay line
// RL11: enable bit 7, refused while secured
// RL12: arm bit 6; run end or writes stop
// RL13: bit 5 selects force or tag break
// RL14: bit 4 enables break requests on triggers
// RL15: bits 2,3 qualify comparator A direction
// RL16: bits 0,1 qualify comparator B direction
// RL17: control register accessible at any time
// RL18: registers decoded in normal memory map
// RL19: four-bit mode field selects trigger condition
// RL20: run ends on full or trigger
`timescale 1ns/1ps

module otm_trace_unit
  import otm_pkg::*;
(
  // clock and reset
  input  wire logic            core_clk,
  input  wire logic            rst,
  // cpu bus monitor
  input  wire otm_mon_type     mon,
  input  wire logic            mcu_secure,
  // register port, cpu or serial debug controller
  input  wire otm_reg_req_type req,
  output logic [7:0]           rd_data,
  // cpu break and system reset
  output logic                 break_req,
  output logic                 break_tag,
  output logic                 host_reset_request
);

  otm_state_type s;
  otm_state_type next_s;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic is_event_mode(input logic [7:0] trig);
    return (trig[3:0] == OTM_MODE_EVENT_B) ||
           (trig[3:0] == OTM_MODE_A_EVENT_B);
  endfunction : is_event_mode

  // direction qualifier: rw high means read
  function automatic logic dir_ok(input logic en, input logic want_rd,
                                  input logic rw);
    return !en || (want_rd == rw);
  endfunction : dir_ok

  function automatic logic [OTM_FIFO_DEPTH-1:0][15:0] fifo_push(
    input logic [OTM_FIFO_DEPTH-1:0][15:0] f, input logic [15:0] w);
    return {w, f[OTM_FIFO_DEPTH-1:1]};
  endfunction : fifo_push

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [15:0] c_addr;
    logic        c_valid;
    logic        c_rw;
    logic        ma;
    logic        mb;
    logic        trig_now;
    logic        evt_mode;
    logic        begin_trace;
    logic        store_evt;
    logic        storing;
    logic [15:0] store_word;
    logic [7:0]  ctl_w;
    c_addr      = '0;
    c_valid     = 1'b0;
    c_rw        = 1'b0;
    ma          = 1'b0;
    mb          = 1'b0;
    trig_now    = 1'b0;
    evt_mode    = is_event_mode(s.trig);
    begin_trace = s.trig[OTM_TRG_BEGIN] || evt_mode;
    store_evt   = 1'b0;
    storing     = 1'b0;
    store_word  = '0;
    ctl_w       = req.wdata;

    next_s         = s;
    next_s.rd_data = OTM_READ_ZERO;
    next_s.brk_req = 1'b0;
    next_s.rst_req = 1'b0;
    next_s.brk_tag = s.ctrl[OTM_CTL_TAG]; // RL13
    if (mon.fetch) begin
      next_s.last_fetch = mon.addr;
    end

    // tag qualification compares executed opcodes instead of bus cycles
    if (s.trig[OTM_TRG_QUALIFY]) begin
      c_addr  = mon.exec_addr;
      c_valid = mon.exec;
      c_rw    = 1'b1;
    end else begin
      c_addr  = mon.addr;
      c_valid = mon.valid;
      c_rw    = mon.rw;
    end

    ma = c_valid && (c_addr == s.cmp_a) &&
         dir_ok(s.ctrl[OTM_CTL_DIR_A_EN], s.ctrl[OTM_CTL_DIR_A], c_rw); // RL15
    mb = c_valid && (c_addr == s.cmp_b) &&
         dir_ok(s.ctrl[OTM_CTL_DIR_B_EN], s.ctrl[OTM_CTL_DIR_B], c_rw); // RL16

    unique case (s.trig[3:0]) // RL19
      OTM_MODE_A_ONLY:    trig_now = ma;
      OTM_MODE_A_OR_B:    trig_now = ma || mb;
      OTM_MODE_A_THEN_B:  trig_now = s.af && mb;
      OTM_MODE_EVENT_B:   trig_now = mb;
      OTM_MODE_A_EVENT_B: trig_now = ma;
      OTM_MODE_A_AND_BD:  trig_now = ma && (mon.data == s.cmp_b[7:0]);
      OTM_MODE_A_NOT_BD:  trig_now = ma && (mon.data != s.cmp_b[7:0]);
      OTM_MODE_INSIDE:    trig_now = c_valid && (c_addr >= s.cmp_a) &&
                                     (c_addr <= s.cmp_b);
      OTM_MODE_OUTSIDE:   trig_now = c_valid && ((c_addr < s.cmp_a) ||
                                                 (c_addr > s.cmp_b));
      default:            trig_now = 1'b0;
    endcase

    // event modes capture the bus data byte of each B match from the trigger until full
    if (evt_mode) begin
      store_evt  = mb; // RL7
      store_word = {8'h00, mon.data}; // RL7
    end else begin
      store_evt  = mon.cof;
      store_word = mon.addr;
    end

    ////////////////////////////////////////////////////////////////////////////
    // debug run sequencing
    unique case (s.run)
      OTM_RUN_IDLE: begin
      end
      OTM_RUN_SEEK: begin
        if (ma) next_s.af = 1'b1;
        if (mb) next_s.bf = 1'b1;
        if (trig_now) begin
          next_s.run = OTM_RUN_FILL;
          storing    = store_evt;
        end
      end
      OTM_RUN_FILL: begin
        if (ma) next_s.af = 1'b1;
        if (mb) next_s.bf = 1'b1;
        storing = store_evt;
        if (!begin_trace && trig_now) begin
          next_s.run                  = OTM_RUN_IDLE; // RL20
          next_s.ctrl[OTM_CTL_ARM]    = 1'b0; // RL12
          next_s.brk_req = s.ctrl[OTM_CTL_BRK_EN]; // RL14
        end
      end
    endcase

    if (storing) begin
      next_s.fifo = fifo_push(s.fifo, store_word);
      if (s.cnt != OTM_FIFO_FULL_CNT) begin
        next_s.cnt = s.cnt + 4'h1;
      end
      if (begin_trace && (s.cnt == OTM_FIFO_FULL_CNT - 4'h1)) begin
        next_s.run               = OTM_RUN_IDLE; // RL20
        next_s.ctrl[OTM_CTL_ARM] = 1'b0; // RL12
        next_s.brk_req = s.ctrl[OTM_CTL_BRK_EN]; // RL14
      end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register writes, decoded in the cpu memory map
    if (req.wr) begin // RL18
      unique case (req.addr) // RL4
        OTM_OFS_CMP_A_HIGH: if (!s.ctrl[OTM_CTL_ARM])
                              next_s.cmp_a[15:8] = req.wdata; // RL3
        OTM_OFS_CMP_A_LOW:  if (!s.ctrl[OTM_CTL_ARM])
                              next_s.cmp_a[7:0] = req.wdata; // RL3
        OTM_OFS_CMP_B_HIGH: if (!s.ctrl[OTM_CTL_ARM])
                              next_s.cmp_b[15:8] = req.wdata; // RL3
        OTM_OFS_CMP_B_LOW:  if (!s.ctrl[OTM_CTL_ARM])
                              next_s.cmp_b[7:0] = req.wdata; // RL3
        OTM_OFS_TRIGGER:    if (!s.ctrl[OTM_CTL_ARM])
                              next_s.trig = req.wdata & OTM_TRG_WR_MASK;
        OTM_OFS_CONTROL: begin // RL17
          if (mcu_secure) ctl_w[OTM_CTL_ENABLE] = 1'b0; // RL11
          if (!ctl_w[OTM_CTL_ENABLE]) ctl_w[OTM_CTL_ARM] = 1'b0; // RL12
          next_s.ctrl = ctl_w;
          if (ctl_w[OTM_CTL_ARM] && !s.ctrl[OTM_CTL_ARM]) begin
            // arming starts a fresh run; end traces fill at once
            next_s.af  = 1'b0;
            next_s.bf  = 1'b0;
            next_s.cnt = 4'h0;
            next_s.run = begin_trace ? OTM_RUN_SEEK : OTM_RUN_FILL;
            next_s.brk_req = 1'b0;
          end else if (!ctl_w[OTM_CTL_ARM]) begin
            next_s.run = OTM_RUN_IDLE; // RL12
          end
        end
        OTM_OFS_FORCE_RESET: begin
          // only the serial debug controller may force a reset
          if (req.host && req.wdata[OTM_RST_REQ_BIT]) begin // RL1
            next_s.rst_req = 1'b1; // RL2
          end
        end
        default: begin
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // register reads; fifo low read advances the fifo while unarmed
    if (req.rd) begin
      unique case (req.addr)
        OTM_OFS_CMP_A_HIGH: next_s.rd_data = s.cmp_a[15:8]; // RL3
        OTM_OFS_CMP_A_LOW:  next_s.rd_data = s.cmp_a[7:0];
        OTM_OFS_CMP_B_HIGH: next_s.rd_data = s.cmp_b[15:8];
        OTM_OFS_CMP_B_LOW:  next_s.rd_data = s.cmp_b[7:0];
        OTM_OFS_FIFO_HIGH:
          next_s.rd_data = evt_mode ? OTM_READ_ZERO : s.fifo[0][15:8]; // RL5
        OTM_OFS_FIFO_LOW: begin
          next_s.rd_data = s.fifo[0][7:0]; // RL6
          // armed reads must not disturb the capture order
          if (!s.ctrl[OTM_CTL_ARM] && !storing) begin // RL8
            next_s.fifo = fifo_push(s.fifo, s.last_fetch); // RL9 RL10
          end
        end
        OTM_OFS_CONTROL:    next_s.rd_data = s.ctrl; // RL17
        OTM_OFS_TRIGGER:    next_s.rd_data = s.trig;
        OTM_OFS_STATUS:
          next_s.rd_data = {s.af, s.bf, s.ctrl[OTM_CTL_ARM], 1'b0, s.cnt};
        OTM_OFS_FORCE_RESET: next_s.rd_data = OTM_READ_ZERO; // RL1
        default:            next_s.rd_data = OTM_READ_ZERO;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= OTM_STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign rd_data            = s.rd_data;
  assign break_req          = s.brk_req;
  assign break_tag          = s.brk_tag;
  assign host_reset_request = s.rst_req;

endmodule : otm_trace_unit

// ### verif/otm_cpu_model.sv
// cpu bus as seen by the trace unit monitor
`timescale 1ns/1ps
module otm_cpu_model
  import otm_pkg::*;
(
  // clock
  input wire logic core_clk,
  // monitored bus
  output otm_mon_type mon
);
  initial mon = '0;
  // one bus cycle; reads double as opcode fetches
  task cyc(input logic [15:0] a, input logic [7:0] d, input logic r);
    @(negedge core_clk);
    mon = '{a, d, r, 1'b1, r, 1'b0, 1'b0, a};
    @(negedge core_clk);
    // idle bus shows inverted leftovers, never a stale match
    mon = '{~a, ~d, ~r, 1'b0, 1'b0, 1'b0, 1'b0, ~a};
  endtask : cyc
endmodule : otm_cpu_model

// ### verif/otm_trace_unit_properties.sv
// port checker of the trace unit
`timescale 1ns/1ps
module otm_trace_unit_properties
  import otm_pkg::*;
(
  // clock and reset
  input wire logic            core_clk,
  input wire logic            rst,
  // bus monitor and register port
  input wire otm_mon_type     mon,
  input wire logic            mcu_secure,
  input wire otm_reg_req_type req,
  // results
  input wire logic [7:0]      rd_data,
  input wire logic            break_req,
  input wire logic            break_tag,
  input wire logic            host_reset_request
);
  logic [5:0] ctl_sh;
  // bits 5:0 of control change only by writes
  always_ff @(posedge core_clk) begin
    if (rst)
      ctl_sh <= '0;
    else if (req.wr && req.addr == OTM_OFS_CONTROL)
      ctl_sh <= req.wdata[5:0];
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_rd(logic [3:0] o);
    req.rd && req.addr == o;
  endsequence
  sequence s_rst_wr(logic h);
    req.wr && req.addr == OTM_OFS_FORCE_RESET && req.host == h;
  endsequence
  sequence s_sec_wr;
    mcu_secure && req.wr && req.addr == OTM_OFS_CONTROL;
  endsequence
  property p_force_zero; s_rd(OTM_OFS_FORCE_RESET) |=> rd_data == 8'h00;
  endproperty
  a_force_zero: assert property (p_force_zero) else $error("reset reg");
  property p_user_wr; s_rst_wr(1'b0) |=> !host_reset_request; endproperty
  a_user_wr: assert property (p_user_wr) else $error("user reset");
  property p_host_rst; s_rst_wr(1'b1)
    |=> host_reset_request == $past(req.wdata[0]);
  endproperty
  a_host_rst: assert property (p_host_rst) else $error("host reset");
  // the tag output lags the control register by one more register stage
  property p_tag; req.wr && req.addr == OTM_OFS_CONTROL
    |-> ##2 break_tag == $past(req.wdata[5], 2); endproperty
  a_tag: assert property (p_tag) else $error("tag copy");
  property p_brk_gate; break_req |-> ctl_sh[4]; endproperty
  a_brk_gate: assert property (p_brk_gate) else $error("break gate");
  property p_ctl_rd; s_rd(OTM_OFS_CONTROL) ##0 !req.wr
    |=> rd_data[5:0] == ctl_sh; endproperty
  a_ctl_rd: assert property (p_ctl_rd) else $error("control read");
  // a quiet cycle between write and read, as a byte master spaces them
  property p_secure; s_sec_wr ##1 !req.wr ##1
    (s_rd(OTM_OFS_CONTROL) ##0 mcu_secure) |=> !rd_data[7]; endproperty
  a_secure: assert property (p_secure) else $error("secure enable");
  property p_unmapped; req.rd && req.addr > OTM_OFS_FORCE_RESET
    |=> rd_data == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped");
  property p_brk_once; break_req |=> !break_req; endproperty
  a_brk_once: assert property (p_brk_once) else $error("break twice");
endmodule : otm_trace_unit_properties

bind otm_trace_unit otm_trace_unit_properties u_otm_trace_unit_properties (
  .core_clk(core_clk), .rst(rst), .mon(mon), .mcu_secure(mcu_secure),
  .req(req), .rd_data(rd_data), .break_req(break_req),
  .break_tag(break_tag), .host_reset_request(host_reset_request));

// ### verif/otm_trace_unit_tb_top.sv
// self-checking testbench of the trace unit
`timescale 1ns/1ps
module otm_trace_unit_tb_top import otm_pkg::*; ;
  logic            core_clk = 1'b0;
  logic            rst = 1'b1;
  logic            mcu_secure = 1'b0;
  otm_mon_type     mon;
  otm_reg_req_type req = '0;
  logic [7:0]      rd_data;
  logic            break_req;
  logic            break_tag;
  logic            host_reset_request;
  int              error_cnt = 0;
  int              checks = 0;
  int              brk_cnt = 0;
  int              rst_cnt = 0;
  integer          seed = 32'h43f0;
  logic [7:0]      exp_q[$];
  logic            rd_seen = 1'b0;
  logic [15:0]     a[16];
  logic [7:0]      d[8];
  logic [15:0]     adr;
  logic [3:0]      mode_tab[6] = '{OTM_MODE_A_OR_B, OTM_MODE_A_THEN_B,
    OTM_MODE_A_AND_BD, OTM_MODE_A_NOT_BD, OTM_MODE_INSIDE, OTM_MODE_OUTSIDE};
  // per mode: two quiet bus cycles, then the one that must trigger
  logic [15:0]     cyc_adr[6][3] = '{
    '{16'h3000, 16'h3000, 16'h2000}, '{16'h2000, 16'h1000, 16'h2000},
    '{16'h1000, 16'h2000, 16'h1000}, '{16'h1000, 16'h2000, 16'h1000},
    '{16'h3000, 16'h3000, 16'h1000}, '{16'h1000, 16'h2000, 16'h3000}};
  logic [7:0]      cyc_dat[6][3] = '{
    '{8'h5A, 8'h5A, 8'h5A}, '{8'h5A, 8'h5A, 8'h5A}, '{8'h5A, 8'h00, 8'h00},
    '{8'h00, 8'h5A, 8'h5A}, '{8'h5A, 8'h5A, 8'h5A}, '{8'h5A, 8'h5A, 8'h5A}};

  always #2.5 core_clk = ~core_clk;
  otm_trace_unit u_otm_trace_unit (.core_clk(core_clk), .rst(rst),
    .mon(mon), .mcu_secure(mcu_secure), .req(req), .rd_data(rd_data),
    .break_req(break_req), .break_tag(break_tag),
    .host_reset_request(host_reset_request));
  otm_cpu_model u_otm_cpu_model (.core_clk(core_clk), .mon(mon));

  ////////////////////////////////////////////////////////////////////////////
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [3:0] o, input logic [7:0] v, input logic h = 1'b0);
    @(negedge core_clk);
    req = '{o, 1'b1, 1'b0, v, h};
    @(negedge core_clk);
    req = '0;
  endtask : wr
  task rd(input logic [3:0] o, input logic [7:0] e);
    @(negedge core_clk);
    req = '{o, 1'b0, 1'b1, 8'h00, 1'b0};
    exp_q.push_back(e);
    @(negedge core_clk);
    req = '0;
  endtask : rd
  task report_and_stop();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////////////////
  // read data lands one edge after the read is taken
  always @(posedge core_clk) rd_seen <= req.rd;
  always @(negedge core_clk) begin
    if (rd_seen)
      chk("rd_data", exp_q.pop_front(), rd_data);
    if (break_req === 1'b1)
      brk_cnt++;
    if (host_reset_request === 1'b1)
      rst_cnt++;
  end

  initial begin
    #20000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    for (int i = 0; i < 4; i++) rd(i[3:0], 8'h00);
    rd(OTM_OFS_CONTROL, 8'h00);
    rd(OTM_OFS_FORCE_RESET, 8'h00);
    for (int i = 0; i < 4; i++) begin
      d[i] = 8'($random(seed));
      wr(i[3:0], d[i]);
      rd(i[3:0], d[i]);
    end
    // profiling: the ninth read returns what the first stored
    wr(OTM_OFS_CONTROL, 8'h80);
    wr(OTM_OFS_FIFO_HIGH, 8'hFF);
    for (int k = 0; k < 16; k++) begin
      a[k] = 16'($random(seed));
      u_otm_cpu_model.cyc(a[k], 8'h00, 1'b1);
      adr = (k < 8) ? 16'h0000 : a[k-8];
      rd(OTM_OFS_FIFO_HIGH, adr[15:8]);
      rd(OTM_OFS_FIFO_LOW, adr[7:0]);
    end
    // end trace on write-qualified A, tag break
    adr = 16'($random(seed));
    wr(OTM_OFS_CMP_A_HIGH, adr[15:8]);
    wr(OTM_OFS_CMP_A_LOW, adr[7:0]);
    wr(OTM_OFS_TRIGGER, {4'h0, OTM_MODE_A_ONLY});
    wr(OTM_OFS_CONTROL, 8'hF4);
    wr(OTM_OFS_CMP_A_HIGH, ~adr[15:8]);
    rd(OTM_OFS_CMP_A_HIGH, adr[15:8]);
    u_otm_cpu_model.cyc(adr, 8'h5A, 1'b1);
    rd(OTM_OFS_CONTROL, 8'hF4);
    u_otm_cpu_model.cyc(adr, 8'hA5, 1'b0);
    rd(OTM_OFS_CONTROL, 8'hB4);
    chk("break tag", 8'h01, {7'h00, break_tag});
    // event-only B fills eight bytes, then stops
    adr = 16'($random(seed));
    wr(OTM_OFS_CMP_B_HIGH, adr[15:8]);
    wr(OTM_OFS_CMP_B_LOW, adr[7:0]);
    wr(OTM_OFS_TRIGGER, {4'h0, OTM_MODE_EVENT_B});
    wr(OTM_OFS_CONTROL, 8'hC0);
    for (int i = 0; i < 8; i++) begin
      d[i] = 8'($random(seed));
      u_otm_cpu_model.cyc(adr, d[i], 1'b0);
    end
    rd(OTM_OFS_CONTROL, 8'h80);
    for (int i = 0; i < 8; i++) begin
      rd(OTM_OFS_FIFO_HIGH, 8'h00);
      rd(OTM_OFS_FIFO_LOW, d[i]);
    end
    wr(OTM_OFS_CONTROL, 8'hC0);
    rd(OTM_OFS_CONTROL, 8'hC0);
    wr(OTM_OFS_CONTROL, 8'h80);
    rd(OTM_OFS_CONTROL, 8'h80);
    mcu_secure = 1'b1;
    wr(OTM_OFS_CONTROL, 8'h80);
    rd(OTM_OFS_CONTROL, 8'h00);
    mcu_secure = 1'b0;
    // remaining end-trace modes; A at 1000, B at 2000, 3000 lies outside
    wr(OTM_OFS_CMP_A_HIGH, 8'h10);
    wr(OTM_OFS_CMP_A_LOW, 8'h00);
    wr(OTM_OFS_CMP_B_HIGH, 8'h20);
    wr(OTM_OFS_CMP_B_LOW, 8'h00);
    for (int m = 0; m < 6; m++) begin
      wr(OTM_OFS_TRIGGER, {4'h0, mode_tab[m]});
      wr(OTM_OFS_CONTROL, 8'hC0);
      for (int c = 0; c < 3; c++) begin
        u_otm_cpu_model.cyc(cyc_adr[m][c], cyc_dat[m][c], 1'b0);
        rd(OTM_OFS_CONTROL, (c == 2) ? 8'h80 : 8'hC0);
      end
    end
    // A then event-only B: B before A is not stored, eight B after are
    wr(OTM_OFS_TRIGGER, {4'h0, OTM_MODE_A_EVENT_B});
    wr(OTM_OFS_CONTROL, 8'hC0);
    for (int i = 0; i < 9; i++) begin
      u_otm_cpu_model.cyc((i == 1) ? 16'h1000 : 16'h2000, 8'h5A, 1'b0);
    end
    rd(OTM_OFS_CONTROL, 8'hC0);
    u_otm_cpu_model.cyc(16'h2000, 8'h5A, 1'b0);
    rd(OTM_OFS_CONTROL, 8'h80);
    wr(OTM_OFS_TRIGGER, 8'hFF);
    rd(OTM_OFS_TRIGGER, OTM_TRG_WR_MASK);
    for (int i = 10; i < 16; i++) rd(i[3:0], 8'h00);
    wr(OTM_OFS_FORCE_RESET, 8'h01);
    wr(OTM_OFS_FORCE_RESET, 8'h00, 1'b1);
    wr(OTM_OFS_FORCE_RESET, 8'h01, 1'b1);
    rd(OTM_OFS_FORCE_RESET, 8'h00);
    repeat (3) @(negedge core_clk);
    chk("break pulses", 8'h01, brk_cnt[7:0]);
    chk("reset pulses", 8'h01, rst_cnt[7:0]);
    report_and_stop();
  end
endmodule : otm_trace_unit_tb_top
